// file: hw/pifb_pkg.sv
// constants, field positions and carrier types of the interrupt flag bank
package pifb_pkg;

    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_ENABLE_0  = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_7  = 8'h04;
    localparam logic [7:0] ADDR_STATUS_0  = 8'h08;
    localparam logic [7:0] ADDR_STATUS_7  = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL   = 8'h10;
    localparam logic [7:0] ADDR_PIN_SEL   = 8'h14;
    localparam logic [7:0] ADDR_EVT_STAT  = 8'h18;
    localparam logic [7:0] ADDR_EVT_MASK  = 8'h1C;

    // bit positions in enable and status register 0
    localparam int BIT_TIMER  = 5;
    localparam int BIT_CHANGE = 4;
    localparam int BIT_EXT    = 0;
    // bit positions in enable and status register 7
    localparam int BIT_MEM    = 5;
    localparam int BIT_OSC    = 4;
    localparam int BIT_WAVE   = 0;
    // bit positions in the control register
    localparam int BIT_GIE    = 7;
    localparam int BIT_PERIPHERAL_GROUP_ENABLE   = 6;

    // widths and reset values
    localparam int         EVT_W          = 6;
    localparam int         SEL_W          = 5;
    localparam int         PORT_FLAG_W    = 40;
    localparam logic [7:0] ENABLE_RESET   = 8'h00;
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [4:0] PIN_SEL_RESET  = 5'h02;
    localparam logic [5:0] EVT_RESET      = 6'h00;

    // pulse inputs from the peripheral sources
    typedef struct packed {
        logic wave;
        logic osc;
        logic mem;
        logic tmr;
    } pifb_src_s;

    // event layout of the sticky event status and mask registers
    typedef struct packed {
        logic wave;
        logic osc;
        logic mem;
        logic ext;
        logic chg;
        logic tmr;
    } pifb_evt_s;

endpackage

// file: hw/pifb_pin_select.sv
// selectable pin with rising edge detection for the external interrupt
`timescale 1ns/100ps
`default_nettype none
module pifb_pin_select
    import pifb_pkg::*;
#(
    parameter int NPINS = 32,
    parameter int SELW  = 5
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [NPINS-1:0] pins,
    input  wire logic [SELW-1:0]  sel,
    output logic                  rise
);
    logic picked;
    logic prev_reg;

    // the selected pin, not a fixed one
    assign picked = pins[sel];

    // last level of the selected pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= picked;
        end
    end

    // one-cycle pulse on a low to high change
    assign rise = picked & ~prev_reg;

endmodule
`default_nettype wire

// file: hw/pifb_top.sv
// peripheral interrupt enable and flag bank with apb register access
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pifb_top
    import pifb_pkg::*;
#(
    parameter int NPINS = 32
) (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_B,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [7:0]             PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic      [31:0]            PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic [NPINS-1:0]       PIN_IN,
    input  wire logic [PORT_FLAG_W-1:0] PER_PORT_CHANGE_FLAGS,
    input  wire pifb_src_s              SRC_EVT,
    input  wire logic                   GROUP_OTHER_REQ,
    output logic                        CORE_INT_REQ,
    output logic                        IRQ
);
    logic [7:0]       peripheral_int_enable_0_reg;
    logic [7:0]       peripheral_int_enable_7_reg;
    logic [7:0]       int_control_register_reg;
    logic [SEL_W-1:0] external_pin_select_reg;
    logic             timer_overflow_flag_reg;
    logic             external_pin_flag_reg;
    logic             mem_flag_reg;
    logic             osc_flag_reg;
    logic             wave_flag_reg;
    logic             chg_prev_reg;
    logic [EVT_W-1:0] evt_status_reg;
    logic [EVT_W-1:0] evt_mask_reg;
    logic [31:0]      prdata_reg;
    logic             core_req_reg;
    logic             irq_reg;

    logic             setup;
    logic             acc_wr;
    logic             addr_hit;
    logic [7:0]       wbyte;
    logic [31:0]      read_mux;
    logic             ext_rise;
    logic             pin_change_summary_flag;
    logic             global_int_enable;
    logic             peripheral_group_enable;
    logic             peripheral_int_enable_0_hit;
    logic             peripheral_int_enable_7_hit;
    pifb_evt_s        evt_now;
    logic             st0_wr;

    // apb phase decode
    assign setup  = PSEL & ~PENABLE;
    assign acc_wr = PSEL & PENABLE & PWRITE;
    assign wbyte  = PWDATA[7:0];

    // mapped addresses
    always_comb begin
        unique case (PADDR)
            ADDR_ENABLE_0, ADDR_ENABLE_7, ADDR_STATUS_0, ADDR_STATUS_7,
            ADDR_CONTROL, ADDR_PIN_SEL, ADDR_EVT_STAT, ADDR_EVT_MASK:
                addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // zero-wait slave, error on unmapped access
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_hit;

    // external pin picked through the select register
    pifb_pin_select #(
        .NPINS (NPINS),
        .SELW  (SEL_W)
    ) u_pin_select (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .pins  (PIN_IN),
        .sel   (external_pin_select_reg),
        .rise  (ext_rise)
    );

    // control fields and live change summary
    assign global_int_enable       = int_control_register_reg[BIT_GIE];
    assign peripheral_group_enable = int_control_register_reg[BIT_PERIPHERAL_GROUP_ENABLE];
    assign pin_change_summary_flag = |PER_PORT_CHANGE_FLAGS;

    // enable register 0, only implemented bits stored
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            peripheral_int_enable_0_reg <= ENABLE_RESET;
        end else if (acc_wr && PADDR == ADDR_ENABLE_0) begin
            peripheral_int_enable_0_reg[BIT_TIMER]  <= wbyte[BIT_TIMER];
            peripheral_int_enable_0_reg[BIT_CHANGE] <= wbyte[BIT_CHANGE];
            peripheral_int_enable_0_reg[BIT_EXT]    <= wbyte[BIT_EXT];
        end
    end

    // enable register 7, only implemented bits stored
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            peripheral_int_enable_7_reg <= ENABLE_RESET;
        end else if (acc_wr && PADDR == ADDR_ENABLE_7) begin
            peripheral_int_enable_7_reg[BIT_MEM]  <= wbyte[BIT_MEM];
            peripheral_int_enable_7_reg[BIT_OSC]  <= wbyte[BIT_OSC];
            peripheral_int_enable_7_reg[BIT_WAVE] <= wbyte[BIT_WAVE];
        end
    end

    // global and group enables, pin select
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            int_control_register_reg <= CONTROL_RESET;
            external_pin_select_reg  <= PIN_SEL_RESET;
        end else if (acc_wr && PADDR == ADDR_CONTROL) begin
            int_control_register_reg[BIT_GIE]  <= wbyte[BIT_GIE];
            int_control_register_reg[BIT_PERIPHERAL_GROUP_ENABLE] <= wbyte[BIT_PERIPHERAL_GROUP_ENABLE];
        end else if (acc_wr && PADDR == ADDR_PIN_SEL) begin
            external_pin_select_reg <= wbyte[SEL_W-1:0];
        end
    end

    // status 0 flags: software write, hardware set wins
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_overflow_flag_reg <= 1'b0;
            external_pin_flag_reg   <= 1'b0;
        end else begin
            if (SRC_EVT.tmr) begin
                timer_overflow_flag_reg <= 1'b1;
            end else if (acc_wr && PADDR == ADDR_STATUS_0) begin
                timer_overflow_flag_reg <= wbyte[BIT_TIMER];
            end
            if (ext_rise) begin
                external_pin_flag_reg <= 1'b1;
            end else if (acc_wr && PADDR == ADDR_STATUS_0) begin
                external_pin_flag_reg <= wbyte[BIT_EXT];
            end
        end
    end

    // status 7 flags for the group sources
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mem_flag_reg  <= 1'b0;
            osc_flag_reg  <= 1'b0;
            wave_flag_reg <= 1'b0;
        end else begin
            mem_flag_reg  <= SRC_EVT.mem |
                (acc_wr && PADDR == ADDR_STATUS_7 ? wbyte[BIT_MEM] : mem_flag_reg);
            osc_flag_reg  <= SRC_EVT.osc |
                (acc_wr && PADDR == ADDR_STATUS_7 ? wbyte[BIT_OSC] : osc_flag_reg);
            wave_flag_reg <= SRC_EVT.wave |
                (acc_wr && PADDR == ADDR_STATUS_7 ? wbyte[BIT_WAVE] : wave_flag_reg);
        end
    end

    // gated request towards the core
    assign peripheral_int_enable_0_hit =
        (peripheral_int_enable_0_reg[BIT_TIMER]  & timer_overflow_flag_reg) |
        (peripheral_int_enable_0_reg[BIT_CHANGE] & pin_change_summary_flag) |
        (peripheral_int_enable_0_reg[BIT_EXT]    & external_pin_flag_reg);
    assign peripheral_int_enable_7_hit =
        (peripheral_int_enable_7_reg[BIT_MEM]  & mem_flag_reg) |
        (peripheral_int_enable_7_reg[BIT_OSC]  & osc_flag_reg) |
        (peripheral_int_enable_7_reg[BIT_WAVE] & wave_flag_reg);

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            core_req_reg <= 1'b0;
        end else begin
            core_req_reg <= global_int_enable & (peripheral_int_enable_0_hit |
                (peripheral_group_enable & (peripheral_int_enable_7_hit | GROUP_OTHER_REQ)));
        end
    end
    assign CORE_INT_REQ = core_req_reg;

    // event pulses for the sticky event register
    assign evt_now = '{wave: SRC_EVT.wave, osc: SRC_EVT.osc, mem: SRC_EVT.mem,
                       ext: ext_rise, chg: pin_change_summary_flag & ~chg_prev_reg,
                       tmr: SRC_EVT.tmr};

    // sticky events, write one to clear, set wins
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            chg_prev_reg   <= 1'b0;
            evt_status_reg <= EVT_RESET;
            evt_mask_reg   <= EVT_RESET;
            irq_reg        <= 1'b0;
        end else begin
            chg_prev_reg <= pin_change_summary_flag;
            if (acc_wr && PADDR == ADDR_EVT_STAT) begin
                evt_status_reg <= (evt_status_reg & ~wbyte[EVT_W-1:0]) | evt_now;
            end else begin
                evt_status_reg <= evt_status_reg | evt_now;
            end
            if (acc_wr && PADDR == ADDR_EVT_MASK) begin
                evt_mask_reg <= wbyte[EVT_W-1:0];
            end
            irq_reg <= |(evt_status_reg & evt_mask_reg);
        end
    end
    assign IRQ = irq_reg;

    // read mux, unimplemented bits zero
    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (PADDR)
            ADDR_ENABLE_0: read_mux[7:0] = peripheral_int_enable_0_reg;
            ADDR_ENABLE_7: read_mux[7:0] = peripheral_int_enable_7_reg;
            ADDR_STATUS_0: begin
                read_mux[BIT_TIMER]  = timer_overflow_flag_reg;
                read_mux[BIT_CHANGE] = pin_change_summary_flag;
                read_mux[BIT_EXT]    = external_pin_flag_reg;
            end
            ADDR_STATUS_7: begin
                read_mux[BIT_MEM]  = mem_flag_reg;
                read_mux[BIT_OSC]  = osc_flag_reg;
                read_mux[BIT_WAVE] = wave_flag_reg;
            end
            ADDR_CONTROL:  read_mux[7:0] = int_control_register_reg;
            ADDR_PIN_SEL:  read_mux[SEL_W-1:0] = external_pin_select_reg;
            ADDR_EVT_STAT: read_mux[EVT_W-1:0] = evt_status_reg;
            ADDR_EVT_MASK: read_mux[EVT_W-1:0] = evt_mask_reg;
            default:       read_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !PWRITE) begin
            prdata_reg <= read_mux;
        end
    end
    assign PRDATA = prdata_reg;

    // checks of the bank's behaviour
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    sequence rd_setup(logic [7:0] a);
        PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence
    sequence rd_access;
        PSEL && PENABLE && PREADY;
    endsequence
    sequence gie_on;
        global_int_enable;
    endsequence

    timer_gate_a: assert property (gie_on and (peripheral_int_enable_0_reg[BIT_TIMER] &&
        timer_overflow_flag_reg) |=> CORE_INT_REQ)
        else $error("timer overflow enabled but no core request");
    change_gate_a: assert property (gie_on and (peripheral_int_enable_0_reg[BIT_CHANGE] &&
        pin_change_summary_flag) |=> CORE_INT_REQ)
        else $error("pin change enabled but no core request");
    ext_gate_a: assert property (!peripheral_int_enable_0_reg[BIT_EXT]
        && !peripheral_int_enable_0_reg[BIT_TIMER] && !peripheral_int_enable_0_reg[BIT_CHANGE]
        && !peripheral_group_enable && external_pin_flag_reg |=> !CORE_INT_REQ)
        else $error("disabled external source raised a request");
    group_block_a: assert property (!peripheral_int_enable_0_hit && !peripheral_group_enable
        |=> !CORE_INT_REQ)
        else $error("group source passed without group enable");
    direct_path_a: assert property (gie_on and (peripheral_int_enable_0_hit && !peripheral_group_enable)
        |=> CORE_INT_REQ)
        else $error("enable 0 source blocked by group enable");
    mem_gate_a: assert property (gie_on and (peripheral_group_enable &&
        peripheral_int_enable_7_reg[BIT_MEM] && mem_flag_reg) |=> CORE_INT_REQ)
        else $error("memory task interrupt not raised");
    osc_gate_a: assert property (gie_on and (peripheral_group_enable &&
        peripheral_int_enable_7_reg[BIT_OSC] && osc_flag_reg) |=> CORE_INT_REQ)
        else $error("oscillator rollover interrupt not raised");
    wave_gate_a: assert property (gie_on and (peripheral_group_enable &&
        peripheral_int_enable_7_reg[BIT_WAVE] && wave_flag_reg) |=> CORE_INT_REQ)
        else $error("waveform generator interrupt not raised");
    reserved_zero_a: assert property (rd_setup(ADDR_ENABLE_0) ##1 rd_access
        |-> PRDATA[7:6] == 2'h0 && PRDATA[3:1] == 3'h0)
        else $error("unimplemented enable bits read nonzero");
    ext_flag_a: assert property (ext_rise |=> external_pin_flag_reg ##1
        (external_pin_flag_reg || $past(st0_wr)))
        else $error("external flag not held after event");
    change_live_a: assert property (rd_setup(ADDR_STATUS_0) ##1 rd_access
        |-> PRDATA[BIT_CHANGE] == $past(pin_change_summary_flag))
        else $error("change summary does not follow port flags");
    flag_indep_a: assert property (SRC_EVT.mem && !global_int_enable |=> mem_flag_reg)
        else $error("flag not set while interrupts disabled");
    pin_sel_a: assert property ($rose(PIN_IN[external_pin_select_reg]) &&
        $stable(external_pin_select_reg) |=> external_pin_flag_reg)
        else $error("selected pin edge did not set external flag");
    reset_zero_a: assert property (disable iff (1'b0) !RST_B |->
        peripheral_int_enable_0_reg == 8'h00 && peripheral_int_enable_7_reg == 8'h00
        && !timer_overflow_flag_reg && !external_pin_flag_reg && !mem_flag_reg)
        else $error("bank bits not zero in reset");
    timer_flag_a: assert property (SRC_EVT.tmr |=> timer_overflow_flag_reg)
        else $error("timer overflow flag not set");
    req_off_a: assert property (!global_int_enable |=> !CORE_INT_REQ)
        else $error("core request without global enable");

    // status 0 software write, seen by the hold and clear checks
    assign st0_wr = acc_wr && PADDR == ADDR_STATUS_0;

    sequence st0_read;
        rd_setup(ADDR_STATUS_0) ##1 rd_access;
    endsequence
    sequence evt_pending;
        |(evt_status_reg & evt_mask_reg);
    endsequence

    ext_hold_a: assert property (external_pin_flag_reg && !st0_wr
        |=> external_pin_flag_reg)
        else $error("external flag dropped without a clear");
    ext_clear_a: assert property (st0_wr && !wbyte[BIT_EXT] && !ext_rise
        |=> !external_pin_flag_reg)
        else $error("external flag not cleared by software");
    timer_hold_a: assert property (timer_overflow_flag_reg && !st0_wr
        |=> timer_overflow_flag_reg)
        else $error("timer flag dropped without a clear");
    status_zero_a: assert property (st0_read |-> PRDATA[7:6] == 2'h0
        && PRDATA[3:1] == 3'h0)
        else $error("unimplemented status bits read nonzero");
    irq_raise_a: assert property (evt_pending |=> IRQ)
        else $error("masked-in event did not raise irq");
    irq_quiet_a: assert property (!(|(evt_status_reg & evt_mask_reg)) |=> !IRQ)
        else $error("irq high with no masked-in event");

endmodule
`default_nettype wire

// file: verif/pifb_src_model.sv
// peripheral event sources and candidate pins at the far side of the flag bank
`timescale 1ns/100ps
`default_nettype none
module pifb_src_model
    import pifb_pkg::*;
#(
    parameter int NPINS = 32
) (
    input  wire logic             clk,
    output var  pifb_src_s        src_evt,
    output var  logic [NPINS-1:0] pins
);
    // idle: no event pending, every pin low
    initial begin
        src_evt = '0;
        pins    = '0;
    end

    // one-cycle event pulse, optionally after a delay in cycles
    task automatic pulse(input pifb_src_s ev, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        src_evt <= ev;
        @(posedge clk);
        src_evt <= '0;
    endtask

    // raise one pin for three cycles, one rising edge for the bank
    task automatic pin_pulse(input int idx);
        @(posedge clk);
        pins[idx] <= 1'b1;
        repeat (3) @(posedge clk);
        pins[idx] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_peripheral_interrupt_enable_flag_bank.sv
// self-checking bench for the interrupt enable and flag bank
`timescale 1ns/100ps
`default_nettype none
module tb_peripheral_interrupt_enable_flag_bank
    import pifb_pkg::*;
;
    logic                   clk;
    logic                   rst_b;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [7:0]             paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [PORT_FLAG_W-1:0] pflags;
    logic                   other_req;
    logic                   core_req;
    logic                   irq;
    logic [31:0]            pins;
    pifb_src_s              src;
    logic [31:0]            rd;
    logic                   err;
    logic [31:0]            d;
    logic [7:0]             addrs [8];
    int                     compares = 0;
    int                     miscompares = 0;
    int                     seed;
    int                     sel;
    int                     idx;

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    pifb_top #(.NPINS(32)) i_dut (
        .REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pins),
        .PER_PORT_CHANGE_FLAGS(pflags), .SRC_EVT(src),
        .GROUP_OTHER_REQ(other_req), .CORE_INT_REQ(core_req), .IRQ(irq)
    );

    pifb_src_model #(.NPINS(32)) i_src (.clk(clk), .src_evt(src), .pins(pins));

    // implemented bits of each register in the address table, with the live change bit of status 0 left out
    function automatic logic [31:0] impl_mask(input int i);
        logic [7:0] m [8];
        m = '{8'h31, 8'h31, 8'h21, 8'h31, 8'hC0, 8'h1F, 8'h3F, 8'h3F};
        return {24'h0, m[i]};
    endfunction

    // value each register holds after reset
    function automatic logic [31:0] rst_val(input int i);
        return (addrs[i] == ADDR_PIN_SEL) ? {27'h0, PIN_SEL_RESET} : 32'h0;
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        chk({31'h0, pready}, 32'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // core request is registered: give it three edges
    task automatic req_chk(input logic e);
        repeat (3) @(posedge clk);
        chk({31'h0, core_req}, {31'h0, e});
    endtask

    // every register at its reset value, unmapped read refused
    task automatic check_reset();
        for (int i = 0; i < 8; i++) begin
            rdc(addrs[i], rst_val(i));
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({30'h0, core_req, irq}, 32'h0);
    endtask

    // main sequence
    initial begin
        addrs = '{ADDR_ENABLE_0, ADDR_ENABLE_7, ADDR_STATUS_0, ADDR_STATUS_7,
                  ADDR_CONTROL, ADDR_PIN_SEL, ADDR_EVT_MASK, ADDR_EVT_STAT};
        seed      = 55656;
        rst_b     = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        pflags    = '0;
        other_req = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        check_reset();
        // one bit at a time into both enable registers
        for (int b = 0; b < 8; b++) begin
            wr(ADDR_ENABLE_0, 32'h1 << b);
            rdc(ADDR_ENABLE_0, (32'h1 << b) & 32'h31);
            wr(ADDR_ENABLE_7, 32'h1 << b);
            rdc(ADDR_ENABLE_7, (32'h1 << b) & 32'h31);
        end
        // random writes across the writable registers except the event status
        for (int k = 0; k < 40; k++) begin
            idx = {$random(seed)} % 7;
            d = $random(seed);
            wr(addrs[idx], d);
            rdc(addrs[idx], d & impl_mask(idx));
        end
        // second reset in mid-run
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        check_reset();
        // each source sets only its own flags, all enables off
        for (int j = 0; j < 4; j++) begin
            i_src.pulse(pifb_src_s'(4'h1 << j), j);
            rdc(ADDR_STATUS_0, (j == 0) ? 32'h20 : 32'h0);
            rdc(ADDR_STATUS_7, {26'h0, j == 1, j == 2, 3'h0, j == 3});
            rdc(ADDR_EVT_STAT, 32'h1 << ((j == 0) ? 0 : j + 2));
            wr(ADDR_STATUS_0, 32'h0);
            wr(ADDR_STATUS_7, 32'h0);
            wr(ADDR_EVT_STAT, 32'h3F);
        end
        // external event follows the selected pin only
        sel = {$random(seed)} % 31;
        wr(ADDR_PIN_SEL, 32'(sel));
        wr(ADDR_STATUS_0, 32'h0);
        i_src.pin_pulse(sel + 1);
        rdc(ADDR_STATUS_0, 32'h0);
        i_src.pin_pulse(sel);
        rdc(ADDR_STATUS_0, 32'h1);
        wr(ADDR_STATUS_0, 32'h0);
        rdc(ADDR_STATUS_0, 32'h0);
        // summary bit follows the per-port flags; event interrupt masked then cleared
        sel = {$random(seed)} % PORT_FLAG_W;
        pflags[sel] <= 1'b1;
        rdc(ADDR_STATUS_0, 32'h10);
        wr(ADDR_STATUS_0, 32'h0);
        rdc(ADDR_STATUS_0, 32'h10);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_EVT_MASK, 32'h02);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        pflags <= '0;
        rdc(ADDR_STATUS_0, 32'h0);
        wr(ADDR_EVT_STAT, 32'h02);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // request to the core under global and group gating
        wr(ADDR_STATUS_0, 32'h20);
        wr(ADDR_ENABLE_0, 32'h20);
        wr(ADDR_CONTROL, 32'h80);
        req_chk(1'b1);
        wr(ADDR_ENABLE_0, 32'h0);
        req_chk(1'b0);
        pflags[0] <= 1'b1;
        wr(ADDR_ENABLE_0, 32'h10);
        req_chk(1'b1);
        pflags <= '0;
        req_chk(1'b0);
        wr(ADDR_STATUS_0, 32'h01);
        wr(ADDR_ENABLE_0, 32'h01);
        req_chk(1'b1);
        wr(ADDR_ENABLE_0, 32'h0);
        req_chk(1'b0);
        other_req <= 1'b1;
        req_chk(1'b0);
        wr(ADDR_CONTROL, 32'hC0);
        req_chk(1'b1);
        other_req <= 1'b0;
        wr(ADDR_STATUS_7, 32'h20);
        wr(ADDR_ENABLE_7, 32'h20);
        req_chk(1'b1);
        wr(ADDR_ENABLE_7, 32'h10);
        req_chk(1'b0);
        wr(ADDR_STATUS_7, 32'h11);
        req_chk(1'b1);
        wr(ADDR_ENABLE_7, 32'h01);
        req_chk(1'b1);
        wr(ADDR_STATUS_7, 32'h10);
        req_chk(1'b0);
        wr(ADDR_CONTROL, 32'h40);
        req_chk(1'b0);
        report_and_stop();
    end

    // cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
